// File: include/imu_settle_pkg.sv
// constants and types shared by the sensor end and the host controller
package imu_settle_pkg;
    // register addresses on the sensor's byte-wide port
    localparam logic [6:0] ADDR_IRQ_ROUTE   = 7'h0d;
    localparam logic [6:0] ADDR_ACCEL_RATE  = 7'h10;
    localparam logic [6:0] ADDR_GYRO_RATE   = 7'h11;
    localparam logic [6:0] ADDR_COMMON_FOUR = 7'h13;
    localparam logic [6:0] ADDR_GYRO_FILTER = 7'h16;
    localparam logic [6:0] ADDR_ACCEL_AXES  = 7'h18;
    localparam logic [6:0] ADDR_GYRO_AXES   = 7'h19;
    localparam logic [6:0] ADDR_STATUS      = 7'h1e;
    // field positions
    localparam int RATE_LSB       = 4;
    localparam int ACC_BW_LSB     = 0;
    localparam int SLEEP_BIT      = 6;
    localparam int SCALING_BIT    = 7;
    localparam int MASK_BIT       = 3;
    localparam int HP_EN_BIT      = 6;
    localparam int HP_RST_BIT     = 3;
    localparam int HP_CUT_LSB     = 4;
    localparam int AXES_LSB       = 3;
    localparam int ACC_FLAG_BIT   = 0;
    localparam int GYR_FLAG_BIT   = 1;
    // high-performance disable bits in the common/gyro filter regs
    localparam int ACC_HP_OFF_BIT = 4;
    localparam int GYR_HP_OFF_BIT = 7;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // bring-up values
    localparam logic [7:0] AXES_ALL        = 8'h38;
    localparam logic [7:0] RATE_416_HP     = 8'h60;
    localparam logic [7:0] ROUTE_ACC_READY = 8'h01;
    localparam logic [7:0] ROUTE_GYR_READY = 8'h02;
    // timing
    localparam int CLK_MHZ        = 50;
    localparam int BOOT_MS        = 20;
    localparam int BOOT_CYCLES    = BOOT_MS * 1000 * CLK_MHZ;
    localparam int GYRO_ON_MS     = 80;
    localparam int GYRO_ON_CYCLES = GYRO_ON_MS * 1000 * CLK_MHZ;
    localparam int PD_NS          = 1000;
    localparam int PD_CYCLES      = (PD_NS * CLK_MHZ) / 1000;
    // rate codes: 0 power-down, 1..10 = 13 Hz .. 6.66 kHz
    localparam logic [3:0] RATE_OFF  = 4'h0;
    localparam logic [3:0] RATE_104  = 4'h4;
    localparam logic [3:0] RATE_208  = 4'h5;
    localparam logic [3:0] RATE_416  = 4'h6;
    localparam logic [3:0] RATE_833  = 4'h7;
    localparam logic [3:0] RATE_1K66 = 4'h8;
    localparam logic [3:0] RATE_3K33 = 4'h9;
    localparam logic [3:0] RATE_6K66 = 4'ha;
    localparam logic [6:0] DISCARD_GYRO_LOW  = 7'h02;
    localparam logic [6:0] DISCARD_GYRO_833  = 7'h03;
    localparam logic [6:0] DISCARD_GYRO_1K66 = 7'h04;
    localparam logic [6:0] DISCARD_NOFILT_3K = 7'h02;
    localparam logic [6:0] DISCARD_NOFILT_6K = 7'h04;

    typedef enum logic [1:0] {
        PM_DOWN  = 2'b00,
        PM_LOW   = 2'b01,
        PM_HIGH  = 2'b10,
        PM_SLEEP = 2'b11
    } power_mode_t;

    // bandwidth index: 0=400,1=200,2=100,3=50,4=none
    typedef logic [2:0] bw_idx_t;

    // accel table rows 104 Hz..6.66 kHz, columns by bandwidth index
    function automatic logic [6:0] accel_discard(input logic [3:0] rate, input bw_idx_t bw);
        logic [6:0] base;
        base = 7'h01;
        unique case (rate)
            4'h4: base = (bw == 3'd3) ? 7'h02 : 7'h01;
            4'h5: base = (bw == 3'd3) ? 7'h04 : (bw == 3'd2) ? 7'h02 : 7'h01;
            4'h6: base = (bw == 3'd3) ? 7'h07 : (bw == 3'd2) ? 7'h03 :
                         (bw == 3'd1) ? 7'h02 : 7'h01;
            4'h7: base = (bw == 3'd3) ? 7'h0e : (bw == 3'd2) ? 7'h07 :
                         (bw == 3'd1) ? 7'h04 : 7'h02;
            4'h8: base = (bw == 3'd3) ? 7'h1c : (bw == 3'd2) ? 7'h0e :
                         (bw == 3'd1) ? 7'h08 : 7'h04;
            4'h9: base = (bw == 3'd3) ? 7'h38 : (bw == 3'd2) ? 7'h1c :
                         (bw == 3'd1) ? 7'h10 : 7'h08;
            4'ha: base = (bw == 3'd3) ? 7'h70 : (bw == 3'd2) ? 7'h38 :
                         (bw == 3'd1) ? 7'h20 : 7'h10;
            default: base = 7'h01;
        endcase
        return base;
    endfunction
endpackage

// File: include/imu_link_if.sv
// register port between the sensor end and its host
`timescale 1ns/1ps
interface imu_link_if;
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ready_out;
    logic       booted;
    modport sensor (input wr, rd, addr, wdata, output rdata, ready_out, booted);
    modport host   (output wr, rd, addr, wdata, input rdata, ready_out, booted);
endinterface

// File: logic/imu_sensor_ctrl.sv
// sensor-side mode, settling, filter control and status logic
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module imu_sensor_ctrl #(
    parameter int BOOT_CNT   = imu_settle_pkg::BOOT_CYCLES,
    parameter int GYRO_ON    = imu_settle_pkg::GYRO_ON_CYCLES
) (
    // clock and reset
    input  wire logic CLK,
    input  wire logic SRST,
    // register port
    imu_link_if.sensor LINK,
    // sample ticks from the converter chain
    input  wire logic ACC_TICK,
    input  wire logic GYR_TICK,
    // filter and mode state for the analog/digital chain
    output logic [1:0] ACC_MODE,
    output logic [1:0] GYR_MODE,
    output logic       ACC_AA_ON,
    output logic [2:0] ACC_AA_BW,
    output logic       GYR_HP_ON,
    output logic [1:0] GYR_HP_CUT,
    output logic       GYR_HP_CLEAR,
    output logic [3:0] GYR_LP_SEL,
    output logic       CAL_LOAD
);
    import imu_settle_pkg::*;

    typedef struct packed {
        logic [31:0] boot_cnt;
        logic        booted;
        logic [7:0]  route;
        logic [7:0]  acc_rate;
        logic [7:0]  gyr_rate;
        logic [7:0]  common4;
        logic [7:0]  gyr_filt;
        logic [7:0]  acc_axes;
        logic [7:0]  gyr_axes;
        logic [6:0]  acc_disc;
        logic [6:0]  gyr_disc;
        logic [31:0] gyr_wake;
        logic        acc_flag;
        logic        gyr_flag;
        logic        hp_clear;
        logic [7:0]  rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    power_mode_t acc_pm;
    power_mode_t gyr_pm;
    power_mode_t acc_pm_new;
    power_mode_t gyr_pm_new;
    bw_idx_t     bw_new;
    logic [7:0]  nxt_acc_rate;
    logic [7:0]  nxt_gyr_rate;
    logic [7:0]  nxt_common4;
    logic [7:0]  nxt_gyr_filt;
    logic [7:0]  nxt_acc_axes;
    logic [7:0]  nxt_gyr_axes;
    logic        acc_run;
    logic        gyr_run;

    function automatic power_mode_t mode_of(input logic [3:0] rate, input logic hp_off,
                                            input logic sleep, input logic axes);
        power_mode_t m;
        m = PM_DOWN;
        if (rate != RATE_OFF && axes) begin
            if (sleep) begin
                m = PM_SLEEP;
            end else if (hp_off && rate <= RATE_208) begin
                m = PM_LOW;
            end else begin
                m = PM_HIGH;
            end
        end
        return m;
    endfunction

    function automatic bw_idx_t bw_of(input logic [7:0] rate_reg, input logic scaling);
        bw_idx_t b;
        if (scaling) begin
            b = {1'b0, rate_reg[ACC_BW_LSB +: 2]};
        end else begin
            unique case (rate_reg[RATE_LSB +: 4])
                RATE_208:              b = 3'd2;
                RATE_416:              b = 3'd1;
                RATE_833, RATE_1K66:   b = 3'd0;
                RATE_3K33, RATE_6K66:  b = 3'd4;
                default:               b = 3'd3;
            endcase
        end
        return b;
    endfunction

    always_comb begin
        nxt_acc_rate = s_q.acc_rate;
        nxt_gyr_rate = s_q.gyr_rate;
        nxt_common4  = s_q.common4;
        nxt_gyr_filt = s_q.gyr_filt;
        nxt_acc_axes = s_q.acc_axes;
        nxt_gyr_axes = s_q.gyr_axes;
        if (LINK.wr && s_q.booted) begin
            unique case (LINK.addr)
                ADDR_ACCEL_RATE:  nxt_acc_rate = LINK.wdata;
                ADDR_GYRO_RATE:   nxt_gyr_rate = LINK.wdata;
                ADDR_COMMON_FOUR: nxt_common4  = LINK.wdata;
                ADDR_GYRO_FILTER: nxt_gyr_filt = LINK.wdata;
                ADDR_ACCEL_AXES:  nxt_acc_axes = LINK.wdata;
                ADDR_GYRO_AXES:   nxt_gyr_axes = LINK.wdata;
                default:          nxt_acc_rate = s_q.acc_rate;
            endcase
        end
        acc_pm = mode_of(s_q.acc_rate[RATE_LSB +: 4], s_q.common4[ACC_HP_OFF_BIT], 1'b0,
                         |s_q.acc_axes[AXES_LSB +: 3]);
        gyr_pm = mode_of(s_q.gyr_rate[RATE_LSB +: 4], s_q.gyr_filt[GYR_HP_OFF_BIT],
                         s_q.common4[SLEEP_BIT], |s_q.gyr_axes[AXES_LSB +: 3]);
        acc_pm_new = mode_of(nxt_acc_rate[RATE_LSB +: 4], nxt_common4[ACC_HP_OFF_BIT], 1'b0,
                             |nxt_acc_axes[AXES_LSB +: 3]);
        gyr_pm_new = mode_of(nxt_gyr_rate[RATE_LSB +: 4], nxt_gyr_filt[GYR_HP_OFF_BIT],
                             nxt_common4[SLEEP_BIT], |nxt_gyr_axes[AXES_LSB +: 3]);
        bw_new = bw_of(nxt_acc_rate, nxt_common4[SCALING_BIT]);
        acc_run = (acc_pm == PM_LOW) || (acc_pm == PM_HIGH);
        gyr_run = (gyr_pm == PM_LOW || gyr_pm == PM_HIGH) && s_q.gyr_wake == 32'd0;

        s_d = s_q;
        s_d.acc_rate = nxt_acc_rate;
        s_d.gyr_rate = nxt_gyr_rate;
        s_d.common4  = nxt_common4;
        s_d.gyr_axes = nxt_gyr_axes;
        s_d.acc_axes = nxt_acc_axes;
        s_d.gyr_filt = nxt_gyr_filt;
        s_d.hp_clear = 1'b0;
        if (LINK.wr && s_q.booted && LINK.addr == ADDR_IRQ_ROUTE) begin
            s_d.route = LINK.wdata;
        end

        if (!s_q.booted) begin
            if (s_q.boot_cnt == 32'(BOOT_CNT - 1)) begin
                s_d.booted = 1'b1;
            end else begin
                s_d.boot_cnt = s_q.boot_cnt + 32'd1;
            end
        end

        if (ACC_TICK && acc_run && s_q.acc_disc != 7'h00) begin
            s_d.acc_disc = s_q.acc_disc - 7'h01;
        end
        if (GYR_TICK && gyr_run && s_q.gyr_disc != 7'h00) begin
            s_d.gyr_disc = s_q.gyr_disc - 7'h01;
        end
        if (nxt_acc_rate != s_q.acc_rate || acc_pm_new != acc_pm) begin
            if (acc_pm_new != PM_HIGH) begin
                s_d.acc_disc = 7'h00;
            end else if (bw_new == 3'd4) begin
                s_d.acc_disc = (nxt_acc_rate[RATE_LSB +: 4] == RATE_6K66) ?
                               DISCARD_NOFILT_6K : DISCARD_NOFILT_3K;
            end else begin
                s_d.acc_disc = accel_discard(nxt_acc_rate[RATE_LSB +: 4], bw_new);
            end
        end
        if (gyr_pm == PM_DOWN && gyr_pm_new != PM_DOWN) begin
            s_d.gyr_wake = 32'(GYRO_ON);
        end else if (gyr_pm_new == PM_DOWN) begin
            s_d.gyr_wake = 32'd0;
        end else if (s_q.gyr_wake != 32'd0) begin
            s_d.gyr_wake = s_q.gyr_wake - 32'd1;
        end
        if ((gyr_pm_new == PM_LOW || gyr_pm_new == PM_HIGH) &&
            (gyr_pm != gyr_pm_new || nxt_gyr_rate != s_q.gyr_rate ||
             nxt_acc_rate != s_q.acc_rate)) begin
            s_d.gyr_disc = (nxt_gyr_rate[RATE_LSB +: 4] == RATE_1K66) ? DISCARD_GYRO_1K66 :
                           (nxt_gyr_rate[RATE_LSB +: 4] == RATE_833) ? DISCARD_GYRO_833 :
                           DISCARD_GYRO_LOW;
        end

        if (s_q.gyr_filt[HP_RST_BIT] && GYR_TICK && gyr_run) begin
            s_d.hp_clear = 1'b1;
            if (!(LINK.wr && LINK.addr == ADDR_GYRO_FILTER)) begin
                s_d.gyr_filt[HP_RST_BIT] = 1'b0;
            end
        end

        // new-data flags, set wins over read-clear
        if (LINK.rd && LINK.addr == ADDR_STATUS) begin
            s_d.acc_flag = 1'b0;
            s_d.gyr_flag = 1'b0;
        end
        if (ACC_TICK && acc_run && !(s_q.common4[MASK_BIT] && s_q.acc_disc != 7'h00)) begin
            s_d.acc_flag = 1'b1;
        end
        if (GYR_TICK && gyr_run && !(s_q.common4[MASK_BIT] && s_q.gyr_disc != 7'h00)) begin
            s_d.gyr_flag = 1'b1;
        end
        if (acc_pm_new == PM_DOWN) begin
            s_d.acc_flag = s_d.acc_flag & acc_run;
        end

        unique case (LINK.addr)
            ADDR_IRQ_ROUTE:   s_d.rdata = s_q.route;
            ADDR_ACCEL_RATE:  s_d.rdata = s_q.acc_rate;
            ADDR_GYRO_RATE:   s_d.rdata = s_q.gyr_rate;
            ADDR_COMMON_FOUR: s_d.rdata = s_q.common4;
            ADDR_GYRO_FILTER: s_d.rdata = s_q.gyr_filt;
            ADDR_ACCEL_AXES:  s_d.rdata = s_q.acc_axes;
            ADDR_GYRO_AXES:   s_d.rdata = s_q.gyr_axes;
            ADDR_STATUS:      s_d.rdata = {6'h00, s_q.gyr_flag, s_q.acc_flag};
            default:          s_d.rdata = 8'h00;
        endcase
        if (!LINK.rd) begin
            s_d.rdata = s_q.rdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign LINK.rdata     = s_q.rdata;
    assign LINK.booted    = s_q.booted;
    assign LINK.ready_out = (s_q.route[0] & s_q.acc_flag) | (s_q.route[1] & s_q.gyr_flag);
    assign ACC_MODE       = acc_pm;
    assign GYR_MODE       = gyr_pm;
    assign ACC_AA_ON      = (acc_pm == PM_HIGH) &&
                            (bw_of(s_q.acc_rate, s_q.common4[SCALING_BIT]) != 3'd4);
    assign ACC_AA_BW      = bw_of(s_q.acc_rate, s_q.common4[SCALING_BIT]);
    assign GYR_HP_ON      = s_q.gyr_filt[HP_EN_BIT];
    assign GYR_HP_CUT     = s_q.gyr_filt[HP_CUT_LSB +: 2];
    assign GYR_HP_CLEAR   = s_q.hp_clear;
    assign GYR_LP_SEL     = (gyr_pm == PM_HIGH) ? s_q.gyr_rate[RATE_LSB +: 4] + 4'h8 :
                            s_q.gyr_rate[RATE_LSB +: 4];
    assign CAL_LOAD       = !s_q.booted;
endmodule

// File: logic/imu_host_ctrl.sv
// host-side bring-up sequencer and status poller
`timescale 1ns/1ps
module imu_host_ctrl (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       SRST,
    // sensor link
    imu_link_if.host        LINK,
    // user side
    input  wire logic       START_ACC,
    input  wire logic       START_GYR,
    output logic            BUSY,
    output logic            ACC_NEW,
    output logic            GYR_NEW
);
    import imu_settle_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_AXES = 3'b001,
        H_RATE = 3'b010,
        H_ROUTE = 3'b011,
        H_POLL = 3'b100,
        H_WAIT = 3'b101
    } hstate_t;

    typedef struct packed {
        hstate_t    st;
        logic       gyro;
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       acc_new;
        logic       gyr_new;
    } hs_t;

    hs_t h_q;
    hs_t h_d;

    always_comb begin
        h_d = h_q;
        h_d.wr = 1'b0;
        h_d.rd = 1'b0;
        h_d.acc_new = 1'b0;
        h_d.gyr_new = 1'b0;
        unique case (h_q.st)
            H_IDLE: begin
                if (LINK.booted && (START_ACC || START_GYR)) begin
                    h_d.gyro = !START_ACC;
                    h_d.st = H_AXES;
                end else if (LINK.booted) begin
                    h_d.st = H_POLL;
                end
            end
            H_AXES: begin
                h_d.wr = 1'b1;
                h_d.addr = h_q.gyro ? ADDR_GYRO_AXES : ADDR_ACCEL_AXES;
                h_d.wdata = AXES_ALL;
                h_d.st = H_RATE;
            end
            H_RATE: begin
                h_d.wr = 1'b1;
                h_d.addr = h_q.gyro ? ADDR_GYRO_RATE : ADDR_ACCEL_RATE;
                h_d.wdata = RATE_416_HP;
                h_d.st = H_ROUTE;
            end
            H_ROUTE: begin
                h_d.wr = 1'b1;
                h_d.addr = ADDR_IRQ_ROUTE;
                h_d.wdata = h_q.gyro ? ROUTE_GYR_READY : ROUTE_ACC_READY;
                h_d.st = H_IDLE;
            end
            H_POLL: begin
                h_d.rd = 1'b1;
                h_d.addr = ADDR_STATUS;
                h_d.st = H_WAIT;
            end
            H_WAIT: begin
                if (!h_q.rd) begin
                    h_d.acc_new = LINK.rdata[ACC_FLAG_BIT];
                    h_d.gyr_new = LINK.rdata[GYR_FLAG_BIT];
                    h_d.st = H_IDLE;
                end
            end
            default: h_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    assign LINK.wr    = h_q.wr;
    assign LINK.rd    = h_q.rd;
    assign LINK.addr  = h_q.addr;
    assign LINK.wdata = h_q.wdata;
    assign BUSY       = (h_q.st != H_IDLE) && (h_q.st != H_POLL) && (h_q.st != H_WAIT);
    assign ACC_NEW    = h_q.acc_new;
    assign GYR_NEW    = h_q.gyr_new;
endmodule

// File: dv/imu_link_chk.sv
// assertions on the register port between host and sensor ends
`timescale 1ns/1ps
module imu_link_chk #(
    parameter int BOOT_CNT = 20
) (
    // clock and reset
    input wire logic       CLK,
    input wire logic       SRST,
    // link signals
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ready_out,
    input wire logic       booted
);
    import imu_settle_pkg::*;
    logic [15:0] cnt_q;
    logic [7:0]  route_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // shadow of the routing byte, so ready_out can be tied to its cause
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_q   <= 16'h0000;
            route_q <= 8'h00;
        end else begin
            if (!booted) cnt_q <= cnt_q + 16'h0001;
            if (wr && booted && addr == ADDR_IRQ_ROUTE) route_q <= wdata;
        end
    end
    a_one_strobe: assert property (!(wr && rd))
        else $error("write and read strobes together");
    a_boot_hold: assert property (booted |=> booted)
        else $error("boot flag dropped");
    // counter stops once booted is seen, so it holds the full boot length
    a_boot_time: assert property ($rose(booted) |-> cnt_q == 16'(BOOT_CNT))
        else $error("boot length wrong");
    a_write_booted: assert property (wr |-> booted)
        else $error("write issued before boot done");
    a_acc_bringup: assert property (wr && addr == ADDR_ACCEL_AXES |-> wdata == AXES_ALL
        ##1 wr && addr == ADDR_ACCEL_RATE && wdata == RATE_416_HP
        ##1 wr && addr == ADDR_IRQ_ROUTE && wdata == ROUTE_ACC_READY)
        else $error("accel bring-up sequence wrong");
    a_gyr_bringup: assert property (wr && addr == ADDR_GYRO_AXES |-> wdata == AXES_ALL
        ##1 wr && addr == ADDR_GYRO_RATE && wdata == RATE_416_HP
        ##1 wr && addr == ADDR_IRQ_ROUTE && wdata == ROUTE_GYR_READY)
        else $error("gyro bring-up sequence wrong");
    a_poll_status: assert property (rd |-> addr == ADDR_STATUS)
        else $error("host read outside status");
    a_rdata_hold: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    a_ready_routed: assert property (ready_out |-> route_q != 8'h00)
        else $error("ready shown with no routing");
endmodule

// File: dv/tb.sv
// bench joining host and sensor ends, plus a register-driven sensor
`timescale 1ns/1ps
module tb;
    import imu_settle_pkg::*;
    logic       CLK = 1'b0;
    logic       SRST = 1'b1;
    logic       acc_tick = 1'b0;
    logic       gyr_tick = 1'b0;
    logic       start_acc = 1'b0;
    logic       start_gyr = 1'b0;
    logic       busy, acc_new, gyr_new;
    logic [1:0] b_acc_mode, b_gyr_mode, b_hp_cut;
    logic [2:0] b_aa_bw;
    logic [3:0] b_lp_sel;
    logic       b_aa_on, b_hp_on, b_hp_clr, b_cal;
    logic [7:0] v;
    int         err_total = 0;
    int         checks_done = 0;
    int         acc_cnt = 0, gyr_cnt = 0, clr_cnt = 0;
    logic [6:0] ra [7] = '{ADDR_IRQ_ROUTE, ADDR_ACCEL_RATE, ADDR_GYRO_RATE, ADDR_COMMON_FOUR,
                           ADDR_GYRO_FILTER, ADDR_ACCEL_AXES, ADDR_GYRO_AXES};
    logic [7:0] cm [5] = '{8'h18, 8'h88, 8'h08, 8'h08, 8'h88};
    logic [7:0] rt [5] = '{8'h40, 8'h63, 8'h90, 8'ha0, 8'ha3};
    int         nd [5] = '{0, 7, 2, 4, 112};
    logic [2:0] bw [5] = '{3'd0, 3'd3, 3'd4, 3'd4, 3'd3};
    imu_link_if link_a ();
    imu_link_if link_b ();
    imu_sensor_ctrl #(.BOOT_CNT(20), .GYRO_ON(30)) i_imu_sensor_ctrl (
        .CLK(CLK), .SRST(SRST), .LINK(link_a), .ACC_TICK(acc_tick), .GYR_TICK(gyr_tick),
        .ACC_MODE(), .GYR_MODE(), .ACC_AA_ON(), .ACC_AA_BW(), .GYR_HP_ON(),
        .GYR_HP_CUT(), .GYR_HP_CLEAR(), .GYR_LP_SEL(), .CAL_LOAD());
    // second sensor: the host end owns link_a, so registers are probed here
    imu_sensor_ctrl #(.BOOT_CNT(20), .GYRO_ON(30)) i_imu_sensor_ctrl_b (
        .CLK(CLK), .SRST(SRST), .LINK(link_b), .ACC_TICK(acc_tick), .GYR_TICK(gyr_tick),
        .ACC_MODE(b_acc_mode), .GYR_MODE(b_gyr_mode), .ACC_AA_ON(b_aa_on),
        .ACC_AA_BW(b_aa_bw), .GYR_HP_ON(b_hp_on), .GYR_HP_CUT(b_hp_cut),
        .GYR_HP_CLEAR(b_hp_clr), .GYR_LP_SEL(b_lp_sel), .CAL_LOAD(b_cal));
    imu_host_ctrl i_imu_host_ctrl (
        .CLK(CLK), .SRST(SRST), .LINK(link_a), .START_ACC(start_acc),
        .START_GYR(start_gyr), .BUSY(busy), .ACC_NEW(acc_new), .GYR_NEW(gyr_new));
    imu_link_chk #(.BOOT_CNT(20)) i_imu_link_chk (
        .CLK(CLK), .SRST(SRST), .wr(link_a.wr), .rd(link_a.rd), .addr(link_a.addr),
        .wdata(link_a.wdata), .rdata(link_a.rdata), .ready_out(link_a.ready_out),
        .booted(link_a.booted));
    always #10 CLK = ~CLK;
    always @(posedge CLK) begin
        if (acc_new === 1'b1) acc_cnt++;
        if (gyr_new === 1'b1) gyr_cnt++;
        if (b_hp_clr === 1'b1) clr_cnt++;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge CLK);
        link_b.wr <= 1'b1;
        link_b.addr <= a;
        link_b.wdata <= d;
        @(posedge CLK);
        link_b.wr <= 1'b0;
        repeat (2) @(negedge CLK);
    endtask
    task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge CLK);
        link_b.rd <= 1'b1;
        link_b.addr <= a;
        @(posedge CLK);
        link_b.rd <= 1'b0;
        // data stand for the cycle after the strobe; take them at its closing edge
        @(posedge CLK);
        d = link_b.rdata;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk(d, e);
    endtask
    task automatic tk(input logic a, input logic g);
        @(posedge CLK);
        acc_tick <= a;
        gyr_tick <= g;
        @(posedge CLK);
        acc_tick <= 1'b0;
        gyr_tick <= 1'b0;
    endtask
    // change, clear flags, n masked samples, then one that must show
    task automatic settle(input logic [6:0] a, input logic [7:0] d, input int n,
                          input int w, input logic g);
        wr_reg(a, d);
        repeat (w) @(negedge CLK);
        rd_reg(ADDR_STATUS, v);
        repeat (n) tk(!g, g);
        rdc(ADDR_STATUS, 8'h00);
        tk(!g, g);
        rdc(ADDR_STATUS, g ? 8'h02 : 8'h01);
    endtask
    task automatic host_go(input logic g);
        @(posedge CLK);
        start_acc <= !g;
        start_gyr <= g;
        for (int i = 0; i < 50 && busy !== 1'b1; i++) @(posedge CLK);
        start_acc <= 1'b0;
        start_gyr <= 1'b0;
        for (int i = 0; i < 50 && busy === 1'b1; i++) @(posedge CLK);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        link_b.wr = 1'b0;
        link_b.rd = 1'b0;
        link_b.addr = 7'h00;
        link_b.wdata = 8'h00;
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        chk(8'(b_cal), 8'h01);
        // lands inside the boot count, so it must be dropped
        wr_reg(ADDR_ACCEL_RATE, 8'h60);
        for (int i = 0; i < 100 && link_b.booted !== 1'b1; i++) @(negedge CLK);
        @(negedge CLK);
        chk(8'(b_cal), 8'h00);
        chk(8'(b_acc_mode), 8'(PM_DOWN));
        chk(8'(b_gyr_mode), 8'(PM_DOWN));
        foreach (ra[i]) rdc(ra[i], 8'h00);
        rdc(7'h7f, 8'h00);
        // no data from either sensor until at least one axis is on
        wr_reg(ADDR_ACCEL_AXES, AXES_ALL);
        wr_reg(ADDR_GYRO_AXES, AXES_ALL);
        rdc(ADDR_ACCEL_AXES, AXES_ALL);
        for (int i = 0; i < 5; i++) begin
            wr_reg(ADDR_COMMON_FOUR, cm[i]);
            settle(ADDR_ACCEL_RATE, rt[i], nd[i], 0, 1'b0);
            chk(8'(b_acc_mode), i == 0 ? 8'(PM_LOW) : 8'(PM_HIGH));
            if (i < 2) chk(8'(b_aa_on), 8'(i));
            if (i > 0) chk(8'(b_aa_bw), 8'(bw[i]));
        end
        rdc(ADDR_ACCEL_RATE, 8'ha3);
        wr_reg(ADDR_COMMON_FOUR, 8'h80);
        for (int b = 0; b < 4; b++) begin
            wr_reg(ADDR_ACCEL_RATE, 8'h60 | 8'(b));
            chk(8'(b_aa_bw), 8'(b));
        end
        wr_reg(ADDR_ACCEL_RATE, 8'h00);
        chk(8'(b_acc_mode), 8'(PM_DOWN));
        wr_reg(ADDR_COMMON_FOUR, 8'h08);
        settle(ADDR_GYRO_RATE, 8'h70, 3, 40, 1'b1);
        chk(8'(b_lp_sel), 8'h0f);
        settle(ADDR_GYRO_RATE, 8'h80, 4, 0, 1'b1);
        settle(ADDR_GYRO_RATE, 8'h60, 2, 0, 1'b1);
        chk(8'(b_gyr_mode), 8'(PM_HIGH));
        wr_reg(ADDR_COMMON_FOUR, 8'h48);
        chk(8'(b_gyr_mode), 8'(PM_SLEEP));
        settle(ADDR_COMMON_FOUR, 8'h08, 2, 0, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr_reg(ADDR_GYRO_FILTER, 8'h40 | 8'(c << 4));
            chk(8'(b_hp_on), 8'h01);
            chk(8'(b_hp_cut), 8'(c));
        end
        wr_reg(ADDR_GYRO_FILTER, 8'h48);
        rdc(ADDR_GYRO_FILTER, 8'h48);
        chk(8'(clr_cnt), 8'h00);
        tk(1'b0, 1'b1);
        repeat (3) @(negedge CLK);
        chk(8'(clr_cnt), 8'h01);
        rdc(ADDR_GYRO_FILTER, 8'h40);
        wr_reg(ADDR_GYRO_FILTER, 8'h80);
        wr_reg(ADDR_GYRO_RATE, 8'h40);
        chk(8'(b_gyr_mode), 8'(PM_LOW));
        chk(8'(b_lp_sel), 8'h04);
        wr_reg(ADDR_GYRO_RATE, 8'h00);
        chk(8'(b_gyr_mode), 8'(PM_DOWN));
        host_go(1'b0);
        repeat (4) tk(1'b1, 1'b0);
        repeat (10) @(negedge CLK);
        chk(8'(acc_cnt != 0), 8'h01);
        host_go(1'b1);
        repeat (40) @(negedge CLK);
        repeat (4) tk(1'b0, 1'b1);
        repeat (10) @(negedge CLK);
        chk(8'(gyr_cnt != 0), 8'h01);
        final_report();
    end
    initial begin
        #200us;
        err_total++;
        final_report();
    end
endmodule
